// ===== logic/hscroll_pkg.sv
// Package: opcodes, field positions, reset values and state type for the scroll command decoder
package hscroll_pkg;
	// ----------------------------------------
	// Opcodes and masks
	// ----------------------------------------
	localparam logic [7:0] OP_SETUP_BASE = 8'h26; // 0x26/0x27 four-byte setup
	localparam logic [7:0] OP_SETUP_MASK = 8'hFE; // Ignore direction bit
	localparam logic [7:0] OP_MODE_BASE = 8'h28; // 0x28..0x2B scroll mode
	localparam logic [7:0] OP_MODE_MASK = 8'hFC; // Ignore low two bits
	localparam logic [7:0] OP_RUN_BASE = 8'h2E; // 0x2E stop / 0x2F start
	localparam logic [7:0] OP_RUN_MASK = 8'hFE; // Ignore run bit
	localparam logic [7:0] OP_PUMP_BASE = 8'h30; // 0x30..0x33 pump level
	localparam logic [7:0] OP_PUMP_MASK = 8'hFC; // Ignore level bits
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_DIR = 0; // Direction bit of setup opcode
	localparam int BIT_RUN = 0; // Run bit of run opcode
	localparam int FLD_LSB = 0; // Low bit of 3-bit and 2-bit fields
	localparam int PAGE_MSB = 2; // Page field top bit
	localparam int MODE_MSB = 1; // Mode / pump field top bit
	localparam int SER_MSB = 7; // Serial shift starts at this bit
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic RST_DIR = 1'b0; // Scroll right
	localparam logic [2:0] RST_START = 3'h0; // Start page 0
	localparam logic [2:0] RST_IVAL = 3'h0; // Code 000 = 6 frames
	localparam logic [2:0] RST_END = 3'h7; // End page 7
	localparam logic [1:0] RST_MODE = 2'h0; // Mode code 0
	localparam logic [1:0] RST_PUMP = 2'h0; // Pump level code 0
	localparam logic RST_RUN = 1'b0; // Scrolling stopped
	// ----------------------------------------
	// Interval code to frames per step
	// ----------------------------------------
	localparam logic [7:0] FR_000 = 8'h06;
	localparam logic [7:0] FR_001 = 8'h20;
	localparam logic [7:0] FR_010 = 8'h40;
	localparam logic [7:0] FR_011 = 8'h80;
	localparam logic [7:0] FR_100 = 8'h03;
	localparam logic [7:0] FR_101 = 8'h04;
	localparam logic [7:0] FR_110 = 8'h05;
	localparam logic [7:0] FR_111 = 8'h02;
	// ----------------------------------------
	// Multi-byte sequence states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_OPCODE,
		ST_START,
		ST_IVAL,
		ST_END
	} seq_state_e;
endpackage : hscroll_pkg

// ===== logic/serial_byte_shifter.sv
// Serial host port byte shifter, most significant bit first
`timescale 1ns/1ps
module serial_byte_shifter (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic ser_bit_valid_in,
	input wire logic ser_bit_in,
	input wire logic ser_frame_in,
	output logic byte_valid_out,
	output logic [7:0] byte_out
);
	import hscroll_pkg::*;

	logic [6:0] shift_ff; // Bits gathered so far
	logic [2:0] count_ff; // Bits taken in the current byte

	// ----------------------------------------
	// Shift path
	// ----------------------------------------
	// First bit lands in bit 7 after eight shifts
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			shift_ff <= 7'h00;
			count_ff <= 3'h0;
		end else if (!ser_frame_in) begin
			// Frame dropped: restart the byte, stray bits discarded
			count_ff <= 3'h0;
		end else if (ser_bit_valid_in) begin
			shift_ff <= {shift_ff[5:0], ser_bit_in};
			count_ff <= count_ff + 3'h1;
		end
	end

	// ----------------------------------------
	// Byte output
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			byte_valid_out <= 1'b0;
			byte_out <= 8'h00;
		end else begin
			byte_valid_out <= ser_frame_in && ser_bit_valid_in && (count_ff == 3'h7);
			if (ser_frame_in && ser_bit_valid_in && (count_ff == 3'h7)) begin
				byte_out <= {shift_ff, ser_bit_in};
			end
		end
	end

	a_msb_first_order: assert property (@(posedge clk_in) disable iff (reset_in)
		(ser_frame_in && ser_bit_valid_in && count_ff == 3'h7) |=> (byte_out[SER_MSB] == $past(shift_ff[6])))
		else $error("serial byte not assembled msb first");
endmodule : serial_byte_shifter

// ===== logic/horizontal_scroll_command_decoder.sv
// Horizontal scroll and pump level command decoder
`timescale 1ns/1ps
// Functional notes
// - 0x26/0x27 start setup; bit0 direction
// - Three parameter bytes: start, interval, end
// - Start page from bits 2..0, reset 0
// - Interval code maps to frames per step
// - End page from bits 2..0, reset 7
// - Parameter bits 7..3 are ignored
// - 0x28..0x2B select scroll mode
// - 0x2E stops, 0x2F starts scrolling
// - Deactivate restores unscrolled image
// - 0x30..0x33 select pump level
// - Command bytes need cmd_data_select low
// - Serial bytes shift in msb first
module horizontal_scroll_command_decoder (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic serial_sel_in,
	input wire logic par_write_in,
	input wire logic [7:0] par_byte_in,
	input wire logic cmd_data_select_in,
	input wire logic ser_bit_valid_in,
	input wire logic ser_bit_in,
	input wire logic ser_frame_in,
	output logic scroll_left_out,
	output logic [2:0] start_page_out,
	output logic [2:0] interval_code_out,
	output logic [7:0] step_frames_out,
	output logic [2:0] end_page_out,
	output logic [1:0] scroll_mode_out,
	output logic scroll_run_out,
	output logic restore_image_out,
	output logic [1:0] pump_level_out,
	output logic setup_busy_out
);
	import hscroll_pkg::*;

	// ----------------------------------------
	// Host byte selection
	// ----------------------------------------
	logic ser_valid; // Byte complete from the serial path
	logic [7:0] ser_byte; // Serial byte value
	logic host_valid; // Write strobe from the selected port this cycle
	logic [7:0] host_byte; // Byte from the selected port
	logic cmd_valid; // Write strobe with command select low

	serial_byte_shifter u_shift (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.ser_bit_valid_in(ser_bit_valid_in && serial_sel_in),
		.ser_bit_in(ser_bit_in),
		.ser_frame_in(ser_frame_in),
		.byte_valid_out(ser_valid),
		.byte_out(ser_byte)
	);

	// Serial port uses the select level in the cycle after the last bit
	always_comb begin
		host_valid = serial_sel_in ? ser_valid : par_write_in;
		host_byte = serial_sel_in ? ser_byte : par_byte_in;
		cmd_valid = host_valid && !cmd_data_select_in;
	end

	// ----------------------------------------
	// Opcode decode
	// ----------------------------------------
	seq_state_e state_ff; // Position in a setup sequence
	seq_state_e nxt_state;
	logic is_setup; // 0x26/0x27
	logic is_mode; // 0x28..0x2B
	logic is_run; // 0x2E/0x2F
	logic is_pump; // 0x30..0x33

	always_comb begin
		is_setup = cmd_valid && state_ff == ST_OPCODE && (host_byte & OP_SETUP_MASK) == OP_SETUP_BASE;
		is_mode = cmd_valid && state_ff == ST_OPCODE && (host_byte & OP_MODE_MASK) == OP_MODE_BASE;
		is_run = cmd_valid && state_ff == ST_OPCODE && (host_byte & OP_RUN_MASK) == OP_RUN_BASE;
		is_pump = cmd_valid && state_ff == ST_OPCODE && (host_byte & OP_PUMP_MASK) == OP_PUMP_BASE;
	end

	// ----------------------------------------
	// Sequence state
	// ----------------------------------------
	// Data bytes in mid-sequence are not parameters; they wait out
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OPCODE: if (is_setup) begin
				nxt_state = ST_START;
			end
			ST_START: if (cmd_valid) begin
				nxt_state = ST_IVAL;
			end
			ST_IVAL: if (cmd_valid) begin
				nxt_state = ST_END;
			end
			ST_END: if (cmd_valid) begin
				nxt_state = ST_OPCODE;
			end
			default: nxt_state = ST_OPCODE;
		endcase
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_ff <= ST_OPCODE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------
	// Staged parameters
	// ----------------------------------------
	// Held aside so a broken sequence never touches live settings
	logic dir_pend_ff;
	logic [2:0] start_pend_ff;
	logic [2:0] ival_pend_ff;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			dir_pend_ff <= RST_DIR;
			start_pend_ff <= RST_START;
			ival_pend_ff <= RST_IVAL;
		end else begin
			if (is_setup) begin
				dir_pend_ff <= host_byte[BIT_DIR];
			end
			if (cmd_valid && state_ff == ST_START) begin
				start_pend_ff <= host_byte[PAGE_MSB:FLD_LSB];
			end
			if (cmd_valid && state_ff == ST_IVAL) begin
				ival_pend_ff <= host_byte[PAGE_MSB:FLD_LSB];
			end
		end
	end

	// ----------------------------------------
	// Live settings
	// ----------------------------------------
	logic commit; // Third parameter byte taken
	assign commit = cmd_valid && state_ff == ST_END;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			scroll_left_out <= RST_DIR;
			start_page_out <= RST_START;
			interval_code_out <= RST_IVAL;
			end_page_out <= RST_END;
		end else if (commit) begin
			scroll_left_out <= dir_pend_ff;
			start_page_out <= start_pend_ff;
			interval_code_out <= ival_pend_ff;
			end_page_out <= host_byte[PAGE_MSB:FLD_LSB];
		end
	end

	// Frames per step, loaded with the live code so the output comes from a flop
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			step_frames_out <= FR_000; // Matches the reset interval code
		end else if (commit) begin
			case (ival_pend_ff)
				3'h0: step_frames_out <= FR_000;
				3'h1: step_frames_out <= FR_001;
				3'h2: step_frames_out <= FR_010;
				3'h3: step_frames_out <= FR_011;
				3'h4: step_frames_out <= FR_100;
				3'h5: step_frames_out <= FR_101;
				3'h6: step_frames_out <= FR_110;
				default: step_frames_out <= FR_111;
			endcase
		end
	end

	// ----------------------------------------
	// Mode, run and pump
	// ----------------------------------------
	// No lockout while running: the host keeps that discipline
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			scroll_mode_out <= RST_MODE;
			scroll_run_out <= RST_RUN;
			restore_image_out <= 1'b0;
			pump_level_out <= RST_PUMP;
		end else begin
			if (is_mode) begin
				scroll_mode_out <= host_byte[MODE_MSB:FLD_LSB];
			end
			if (is_run) begin
				scroll_run_out <= host_byte[BIT_RUN];
			end
			// One-cycle pulse asks the datapath to undo the shift
			restore_image_out <= is_run && !host_byte[BIT_RUN];
			if (is_pump) begin
				pump_level_out <= host_byte[MODE_MSB:FLD_LSB];
			end
		end
	end

	assign setup_busy_out = (state_ff != ST_OPCODE);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_setup_three_bytes: assert property (@(posedge clk_in) disable iff (reset_in)
		is_setup |=> (state_ff == ST_START)) else $error("setup opcode did not open sequence");
	a_dir_on_commit: assert property (@(posedge clk_in) disable iff (reset_in)
		commit |=> (scroll_left_out == $past(dir_pend_ff))) else $error("direction not applied");
	a_start_page_take: assert property (@(posedge clk_in) disable iff (reset_in)
		commit |=> start_page_out == $past(start_pend_ff)) else $error("start page wrong");
	a_interval_map: assert property (@(posedge clk_in) disable iff (reset_in)
		interval_code_out == 3'h3 |-> step_frames_out == FR_011) else $error("interval map wrong");
	a_end_page_take: assert property (@(posedge clk_in) disable iff (reset_in)
		commit |=> end_page_out == $past(host_byte[PAGE_MSB:FLD_LSB])) else $error("end page wrong");
	a_high_bits_ignored: assert property (@(posedge clk_in) disable iff (reset_in)
		(cmd_valid && state_ff == ST_START) |=> start_pend_ff == $past(host_byte[2:0]))
		else $error("upper bits leaked");
	a_mode_select: assert property (@(posedge clk_in) disable iff (reset_in)
		is_mode |=> scroll_mode_out == $past(host_byte[1:0])) else $error("mode not taken");
	a_run_flag: assert property (@(posedge clk_in) disable iff (reset_in)
		is_run |=> scroll_run_out == $past(host_byte[0])) else $error("run flag wrong");
	a_restore_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
		(is_run && !host_byte[BIT_RUN]) |=> (restore_image_out && !scroll_run_out))
		else $error("restore pulse missing after stop");
	a_pump_level: assert property (@(posedge clk_in) disable iff (reset_in)
		is_pump |=> pump_level_out == $past(host_byte[1:0])) else $error("pump level wrong");
	a_data_not_cmd: assert property (@(posedge clk_in) disable iff (reset_in)
		(host_valid && cmd_data_select_in && state_ff == ST_OPCODE) |=> $stable(scroll_run_out))
		else $error("data byte decoded as command");
	a_partial_holds: assert property (@(posedge clk_in) disable iff (reset_in)
		(state_ff != ST_END) |=> $stable(end_page_out)) else $error("partial setup applied");
	a_idle_after_reset: assert property (@(posedge clk_in)
		$fell(reset_in) |-> state_ff == ST_OPCODE) else $error("sequence state kept over reset");
	c_full_setup: cover property (@(posedge clk_in) disable iff (reset_in) commit);
	c_start_scroll: cover property (@(posedge clk_in) disable iff (reset_in) is_run && host_byte[0]);
	c_stop_scroll: cover property (@(posedge clk_in) disable iff (reset_in) restore_image_out);
	c_pump_set: cover property (@(posedge clk_in) disable iff (reset_in) is_pump);
endmodule : horizontal_scroll_command_decoder

// ===== test/host_model.sv
// Host-side model that writes command bytes over the parallel or serial port
`timescale 1ns/1ps
module host_model (
	input wire logic clk_in,
	output logic serial_sel_out,
	output logic par_write_out,
	output logic [7:0] par_byte_out,
	output logic cmd_data_select_out,
	output logic ser_bit_valid_out,
	output logic ser_bit_out,
	output logic ser_frame_out
);
	// ----------------------------------------
	// Idle levels at time zero
	// ----------------------------------------
	initial begin
		serial_sel_out = 1'b0;
		par_write_out = 1'b0;
		par_byte_out = 8'h00;
		cmd_data_select_out = 1'b1;
		ser_bit_valid_out = 1'b0;
		ser_bit_out = 1'b0;
		ser_frame_out = 1'b0;
	end
	// ----------------------------------------
	// Drive tasks, all entered at a falling edge
	// ----------------------------------------
	// Port select, level
	task automatic select_port(input logic ser);
		serial_sel_out = ser;
	endtask : select_port
	// Parallel byte; strobe left up so writes may run back to back
	task automatic send_par(input logic [7:0] b, input logic cd);
		par_write_out = 1'b1;
		par_byte_out = b;
		cmd_data_select_out = cd;
		@(negedge clk_in);
	endtask : send_par
	// Released lines are not held: show the inverse, no pull on them
	task automatic release_bus();
		par_write_out = 1'b0;
		par_byte_out = ~par_byte_out;
		cmd_data_select_out = ~cmd_data_select_out;
		ser_bit_valid_out = 1'b0;
	endtask : release_bus
	// Serial byte, top bit first; select held past its sampling cycle
	task automatic send_ser(input logic [7:0] b, input logic cd);
		ser_frame_out = 1'b1;
		cmd_data_select_out = cd;
		for (int i = 7; i >= 0; i--) begin
			ser_bit_out = b[i];
			ser_bit_valid_out = 1'b1;
			@(negedge clk_in);
		end
		ser_bit_valid_out = 1'b0;
		ser_bit_out = ~ser_bit_out;
		repeat (2) @(negedge clk_in);
	endtask : send_ser
	// Half a byte, then the frame drops: must be thrown away
	task automatic send_partial(input logic [3:0] b);
		ser_frame_out = 1'b1;
		for (int i = 3; i >= 0; i--) begin
			ser_bit_out = b[i];
			ser_bit_valid_out = 1'b1;
			@(negedge clk_in);
		end
		ser_bit_valid_out = 1'b0;
		end_frame();
		@(negedge clk_in);
	endtask : send_partial
	// Frame end; data line no longer meaningful
	task automatic end_frame();
		ser_frame_out = 1'b0;
		ser_bit_out = ~ser_bit_out;
	endtask : end_frame
endmodule : host_model

// ===== test/tb.sv
// Self-checking bench for the scroll command decoder
`timescale 1ns/1ps
module tb;
	// ----------------------------------------
	// Nets, expected state and counters
	// ----------------------------------------
	logic clk_in, reset_in, serial_sel_in, par_write_in, cmd_data_select_in;
	logic ser_bit_valid_in, ser_bit_in, ser_frame_in;
	logic [7:0] par_byte_in, step_frames_out;
	logic scroll_left_out, scroll_run_out, restore_image_out, setup_busy_out;
	logic [2:0] start_page_out, interval_code_out, end_page_out;
	logic [1:0] scroll_mode_out, pump_level_out;
	integer seed = 32'h515976df; // Fixed seed, repeatable run
	int n_mismatch = 0;
	int comparisons = 0;
	logic e_dir, e_run, use_ser; // Expected flags; port in use
	logic [2:0] e_start, e_ival, e_end;
	logic [1:0] e_mode, e_pump;
	// ----------------------------------------
	// Clock, partner and design
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	host_model host (.clk_in(clk_in), .serial_sel_out(serial_sel_in), .par_write_out(par_write_in),
		.par_byte_out(par_byte_in), .cmd_data_select_out(cmd_data_select_in),
		.ser_bit_valid_out(ser_bit_valid_in), .ser_bit_out(ser_bit_in), .ser_frame_out(ser_frame_in));
	horizontal_scroll_command_decoder DUT (.clk_in(clk_in), .reset_in(reset_in), .serial_sel_in(serial_sel_in),
		.par_write_in(par_write_in), .par_byte_in(par_byte_in), .cmd_data_select_in(cmd_data_select_in),
		.ser_bit_valid_in(ser_bit_valid_in), .ser_bit_in(ser_bit_in), .ser_frame_in(ser_frame_in),
		.scroll_left_out(scroll_left_out), .start_page_out(start_page_out),
		.interval_code_out(interval_code_out), .step_frames_out(step_frames_out),
		.end_page_out(end_page_out), .scroll_mode_out(scroll_mode_out), .scroll_run_out(scroll_run_out),
		.restore_image_out(restore_image_out), .pump_level_out(pump_level_out),
		.setup_busy_out(setup_busy_out));
	// ----------------------------------------
	// Expectation helpers and compares
	// ----------------------------------------
	// Frames per step from the interval code
	function automatic logic [7:0] frames(input logic [2:0] c);
		logic [7:0] tbl [8];
		tbl = '{8'h06, 8'h20, 8'h40, 8'h80, 8'h03, 8'h04, 8'h05, 8'h02};
		return tbl[c];
	endfunction : frames
	// Power-on settings
	task automatic set_defaults();
		{e_dir, e_start, e_ival, e_end, e_mode, e_run, e_pump} = {1'b0, 3'h0, 3'h0, 3'h7, 2'h0, 1'b0, 2'h0};
	endtask : set_defaults
	// Single compare, four-state exact
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// All standing settings at once
	task automatic chk_all();
		chk("scroll_left", {7'h00, e_dir}, {7'h00, scroll_left_out});
		chk("start_page", {5'h00, e_start}, {5'h00, start_page_out});
		chk("interval_code", {5'h00, e_ival}, {5'h00, interval_code_out});
		chk("step_frames", frames(e_ival), step_frames_out);
		chk("end_page", {5'h00, e_end}, {5'h00, end_page_out});
		chk("scroll_mode", {6'h00, e_mode}, {6'h00, scroll_mode_out});
		chk("scroll_run", {7'h00, e_run}, {7'h00, scroll_run_out});
		chk("pump_level", {6'h00, e_pump}, {6'h00, pump_level_out});
	endtask : chk_all
	// ----------------------------------------
	// Byte and command tasks
	// ----------------------------------------
	task automatic xfer(input logic [7:0] b, input logic cd);
		if (use_ser) begin
			host.send_ser(b, cd);
		end else begin
			host.send_par(b, cd);
		end
	endtask : xfer
	// One command, then a quiet cycle so the strobe is not reassigned at once
	task automatic cmd(input logic [7:0] b);
		xfer(b, 1'b0);
		host.release_bus();
		@(negedge clk_in);
	endtask : cmd
	// Full setup with a data byte slipped in and a mid-way look
	task automatic setup(input logic [7:0] op, input logic [7:0] p1, input logic [7:0] p2, input logic [7:0] p3);
		cmd(8'h2E);
		e_run = 1'b0;
		xfer(op, 1'b0);
		xfer(p1, 1'b0);
		xfer(8'($random(seed)), 1'b1);
		xfer(p2, 1'b0);
		host.release_bus();
		@(negedge clk_in);
		chk("setup_busy", 8'h01, {7'h00, setup_busy_out});
		chk_all();
		cmd(p3);
		{e_dir, e_start, e_ival, e_end} = {op[0], p1[2:0], p2[2:0], p3[2:0]};
		chk("setup_busy", 8'h00, {7'h00, setup_busy_out});
		chk_all();
	endtask : setup
	// ----------------------------------------
	// Verdict and watchdog
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	// Run needs well under two thousand cycles; allow ten times that
	initial begin
		#160000;
		n_mismatch++;
		tally_and_finish();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] r;
		reset_in = 1'b1;
		use_ser = 1'b0;
		set_defaults();
		repeat (4) @(negedge clk_in);
		reset_in = 1'b0;
		chk_all();
		// Every interval code, random pages and junk upper bits
		for (int k = 0; k < 8; k++) begin
			r = 8'($random(seed));
			setup(8'h26 | 8'(k[0]), 8'($random(seed)), {r[7:3], 3'(k)}, 8'($random(seed)));
		end
		setup(8'h27, 8'hFF, 8'hF8, 8'h00);
		// Every mode and pump code
		for (int k = 0; k < 4; k++) begin
			cmd(8'h28 + 8'(k));
			cmd(8'h30 + 8'(k));
			{e_mode, e_pump} = {2'(k), 2'(k)};
			chk_all();
		end
		// A run opcode sent as data must not start anything
		xfer(8'h2F, 1'b1);
		host.release_bus();
		@(negedge clk_in);
		chk_all();
		// Start after full setup, then stop with its restore pulse
		cmd(8'h2F);
		e_run = 1'b1;
		chk_all();
		xfer(8'h2E, 1'b0);
		host.release_bus();
		e_run = 1'b0;
		chk("restore_image", 8'h01, {7'h00, restore_image_out});
		chk_all();
		@(negedge clk_in);
		chk("restore_image", 8'h00, {7'h00, restore_image_out});
		// Serial port: a dropped partial byte, then a setup and a pump code
		host.select_port(1'b1);
		use_ser = 1'b1;
		host.send_partial(4'hA);
		setup(8'h27, 8'hB3, 8'h06, 8'h44);
		cmd(8'h33);
		e_pump = 2'h3;
		chk_all();
		host.end_frame();
		host.select_port(1'b0);
		use_ser = 1'b0;
		@(negedge clk_in);
		// Reset in mid-setup; next byte must decode as an opcode
		xfer(8'h26, 1'b0);
		xfer(8'h05, 1'b0);
		host.release_bus();
		reset_in = 1'b1;
		@(negedge clk_in);
		set_defaults();
		chk_all();
		reset_in = 1'b0;
		cmd(8'h32);
		e_pump = 2'h2;
		chk("setup_busy", 8'h00, {7'h00, setup_busy_out});
		chk_all();
		tally_and_finish();
	end
endmodule : tb
